/* File: bench/pad_world_model.sv */
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Board side of the pads: drivers, weak pullups and floating nets
// ------------------------------------------------------------------
module pad_world_model
   import crossbar_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic [PIN_COUNT-1:0] padOut,
   input  wire logic [PIN_COUNT-1:0] padOe,
   input  wire logic [PIN_COUNT-1:0] pullupOn,
   output logic      [PIN_COUNT-1:0] padIn
);
   // Level of a pad nobody drives or pulls.
   logic [PIN_COUNT-1:0] floatLvl;

   // A floating net flips every cycle, so a stale value never passes.
   initial floatLvl = 16'h5A3C;
   always @(negedge clk) begin
      floatLvl <= ~floatLvl;
   end

   // Driver wins, then the weak pullup, then the floating level.
   always_comb begin
      for (int n = 0; n < PIN_COUNT; n++) begin
         padIn[n] = padOe[n] ? padOut[n] : (pullupOn[n] | floatLvl[n]);
      end
   end
endmodule

/* File: bench/tb_priority_crossbar_pin_assign.sv */
`timescale 1ns/100ps

module tb_priority_crossbar_pin_assign
   import crossbar_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic [7:0]            sfrAddr = 8'h00;
   logic                  sfrWrEn = 1'b0;
   logic [7:0]            sfrWrData = 8'h00;
   logic                  sfrRdEn = 1'b0;
   logic [7:0]            sfrRdData;
   logic [1:0]            slaveSelectMode = 2'h0;
   logic [PIN_COUNT-1:0]  gpioOut = 16'h0000;
   logic [PIN_COUNT-1:0]  gpioIn;
   logic [FUNC_COUNT-1:0] funcOut = 11'h000;
   logic [FUNC_COUNT-1:0] funcOe = 11'h000;
   logic [FUNC_COUNT-1:0] funcIn;
   logic [PIN_COUNT-1:0]  padIn;
   logic [PIN_COUNT-1:0]  padOut;
   logic [PIN_COUNT-1:0]  padOe;
   logic [PIN_COUNT-1:0]  pullupOn;
   logic [PIN_COUNT-1:0]  inputEnable;
   int                    mismatches = 0;
   int                    comparisons = 0;
   int                    seed = 3;
   int                    cycles = 0;
   int                    liveCnt = 0;
   // Register mirror and the expected outputs after the coming edge.
   logic [7:0]            rF, rS;
   logic [15:0]           inKind, drive, bypass;
   logic [15:0]           eOe, eOut, ePu, eIe, eGin;
   logic [10:0]           eFin;
   logic [7:0]            eRd;
   logic [7:0]            addrTab [9] = '{ADDR_ROUTE_FIRST, ADDR_ROUTE_SECOND,
      ADDR_INKIND_P0, ADDR_INKIND_P1, ADDR_DRIVE_P0, ADDR_DRIVE_P1,
      ADDR_BYPASS_P0, ADDR_BYPASS_P1, 8'h80};

   always #5 clk = ~clk;

   priority_crossbar_pin_assign DUT (
      .clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
      .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
      .slaveSelectMode(slaveSelectMode), .gpioOut(gpioOut),
      .gpioIn(gpioIn), .funcOut(funcOut), .funcOe(funcOe),
      .funcIn(funcIn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
      .pullupOn(pullupOn), .inputEnable(inputEnable));

   pad_world_model pads (
      .clk(clk), .padOut(padOut), .padOe(padOe), .pullupOn(pullupOn),
      .padIn(padIn));

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   // Read-back view of the mirror; unused bits and holes read zero.
   function automatic logic [7:0] rdback(input logic [7:0] a);
      case (a)
         ADDR_ROUTE_FIRST:  return rF & 8'h3F;
         ADDR_ROUTE_SECOND: return rS & 8'hC0;
         ADDR_INKIND_P0:    return inKind[7:0];
         ADDR_INKIND_P1:    return inKind[15:8];
         ADDR_DRIVE_P0:     return drive[7:0];
         ADDR_DRIVE_P1:     return drive[15:8];
         ADDR_BYPASS_P0:    return bypass[7:0];
         ADDR_BYPASS_P1:    return bypass[15:8];
         default:           return 8'h00;
      endcase
   endfunction

   // Work out the next outputs from the state before this edge.
   always @(posedge clk or negedge rst_n) begin
      int q[$];
      int pinFn[PIN_COUNT];
      int fn, p;
      logic req, val, od, dig;
      if (!rst_n) begin
         {rF, rS, drive, bypass} = '0;
         inKind = 16'hFFFF;
         liveCnt = 0;
      end else begin
         liveCnt++;
         q = {};
         pinFn = '{default: 0};
         if (rF[0]) begin
            pinFn[SERIAL_TX_PIN] = 1;
            pinFn[SERIAL_RX_PIN] = 2;
         end
         if (rF[1])
            q = {3, 4, 5};
         if (rF[1] && slaveSelectMode != 2'h0)
            q.push_back(6);
         if (rF[2])
            q = {q, 7, 8};
         if (rF[4])
            q.push_back(9);
         if (rF[5])
            q.push_back(10);
         if (rF[3])
            q.push_back(11);
         // Lowest pin that is neither bypassed nor already taken.
         foreach (q[i]) begin
            p = 0;
            while (p < PIN_COUNT && (bypass[p] || pinFn[p] != 0))
               p++;
            if (p < PIN_COUNT)
               pinFn[p] = q[i];
         end
         eFin = 11'h7FF;
         for (int n = 0; n < PIN_COUNT; n++) begin
            fn = pinFn[n];
            dig = inKind[n];
            req = (fn == 0) ? 1'b1 : funcOe[(fn + 10) % 11];
            val = (fn == 0) ? gpioOut[n] : funcOut[(fn + 10) % 11];
            od = !drive[n] || fn == 7 || fn == 8;
            eOe[n] = rS[6] && dig && req && (!od || !val);
            eOut[n] = !od && val;
            ePu[n] = dig && !rS[7] && (rS[6] ? od && !eOe[n] : 1'b1);
            eIe[n] = dig;
            eGin[n] = dig && padIn[n];
            if (rS[6] && dig && fn != 0)
               eFin[fn-1] = padIn[n];
         end
         eRd = sfrRdEn ? rdback(sfrAddr) : 8'h00;
         if (sfrWrEn) begin
            case (sfrAddr)
               ADDR_ROUTE_FIRST:  rF = sfrWrData;
               ADDR_ROUTE_SECOND: rS = sfrWrData;
               ADDR_INKIND_P0:    inKind[7:0] = sfrWrData;
               ADDR_INKIND_P1:    inKind[15:8] = sfrWrData;
               ADDR_DRIVE_P0:     drive[7:0] = sfrWrData;
               ADDR_DRIVE_P1:     drive[15:8] = sfrWrData;
               ADDR_BYPASS_P0:    bypass[7:0] = sfrWrData;
               ADDR_BYPASS_P1:    bypass[15:8] = sfrWrData;
               default:           ;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Checking and reporting
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      if (mismatches == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Outputs settle at the edge; compare half a cycle later.
   always @(negedge clk) begin
      if (rst_n && liveCnt > 3) begin
         chk(padOe, eOe);
         chk(padOut & eOe, eOut & eOe);
         chk(pullupOn, ePu);
         chk(inputEnable, eIe);
         chk(gpioIn, eGin);
         chk({5'h00, funcIn}, {5'h00, eFin});
         chk({8'h00, sfrRdData}, {8'h00, eRd});
      end
   end

   // A hang is cut short well above the planned length of the run.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         mismatches++;
         close_out();
      end
   end

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   // One register access; an idle edge follows so strobes never merge.
   task automatic sfr_op(input logic rd, input logic [7:0] a,
                         input logic [7:0] d);
      @(posedge clk);
      #1;
      sfrAddr = a;
      sfrWrData = d;
      sfrWrEn = !rd;
      sfrRdEn = rd;
      @(posedge clk);
      #1;
      sfrWrEn = 1'b0;
      sfrRdEn = 1'b0;
   endtask

   // Random peripheral and latch traffic, optionally random accesses.
   task automatic rnd_cycles(input int n, input logic acc);
      repeat (n) begin
         @(posedge clk);
         #1;
         gpioOut = 16'($random(seed));
         funcOut = 11'($random(seed));
         funcOe = 11'($random(seed));
         slaveSelectMode = 2'($random(seed));
         sfrAddr = addrTab[($random(seed) & 32'h7FFF) % 9];
         sfrWrData = 8'($random(seed));
         sfrWrEn = acc && (($random(seed) & 3) == 0);
         sfrRdEn = acc && (($random(seed) & 3) == 1);
      end
   endtask

   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge clk);
      foreach (addrTab[i])
         sfr_op(1'b1, addrTab[i], 8'h00);
      sfr_op(1'b0, ADDR_ROUTE_FIRST, 8'hFF);
      sfr_op(1'b1, ADDR_ROUTE_FIRST, 8'h00);
      rnd_cycles(20, 1'b0);
      sfr_op(1'b0, ADDR_INKIND_P0, 8'hB6);
      sfr_op(1'b0, ADDR_DRIVE_P0, 8'h0F);
      sfr_op(1'b0, ADDR_BYPASS_P0, 8'h49);
      sfr_op(1'b0, ADDR_ROUTE_FIRST, 8'h3F);
      sfr_op(1'b0, ADDR_ROUTE_SECOND, 8'h40);
      rnd_cycles(40, 1'b0);
      sfr_op(1'b0, ADDR_ROUTE_SECOND, 8'hC0);
      rnd_cycles(20, 1'b0);
      rnd_cycles(4000, 1'b1);
      close_out();
   end
endmodule

/* File: shared/crossbar_pkg.sv */
package crossbar_pkg;

   // ------------------------------------------------------------------
   // Geometry of the routed ports
   // ------------------------------------------------------------------
   localparam int PIN_COUNT  = 16;   // Port 0 pins 0..7, port 1 pins 8..15.
   localparam int FUNC_COUNT = 11;   // Routable peripheral signals.
   localparam int SERIAL_TX_PIN = 4; // Fixed transmit pin of port 0.
   localparam int SERIAL_RX_PIN = 5; // Fixed receive pin of port 0.

   // ------------------------------------------------------------------
   // Special function register addresses
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_ROUTE_FIRST  = 8'hE1;
   localparam logic [7:0] ADDR_ROUTE_SECOND = 8'hE2;
   localparam logic [7:0] ADDR_INKIND_P0    = 8'hF1;
   localparam logic [7:0] ADDR_INKIND_P1    = 8'hF2;
   localparam logic [7:0] ADDR_DRIVE_P0     = 8'hA4;
   localparam logic [7:0] ADDR_DRIVE_P1     = 8'hA5;
   localparam logic [7:0] ADDR_BYPASS_P0    = 8'hD4;
   localparam logic [7:0] ADDR_BYPASS_P1    = 8'hD5;

   // ------------------------------------------------------------------
   // Field positions, masks and reset values
   // ------------------------------------------------------------------
   localparam int BIT_CMP_ASYNC  = 5;
   localparam int BIT_CMP        = 4;
   localparam int BIT_SYSCLK     = 3;
   localparam int BIT_TWOWIRE    = 2;
   localparam int BIT_SPI        = 1;
   localparam int BIT_SERIAL     = 0;
   localparam int BIT_PULLUP_OFF = 7;
   localparam int BIT_XBAR_ON    = 6;
   localparam logic [7:0] ROUTE_FIRST_MASK  = 8'h3F;
   localparam logic [7:0] ROUTE_SECOND_MASK = 8'hC0;
   localparam logic [7:0] ROUTE_FIRST_RST   = 8'h00;
   localparam logic [7:0] ROUTE_SECOND_RST  = 8'h00;
   localparam logic [7:0] INKIND_RST        = 8'hFF;
   localparam logic [7:0] DRIVE_RST         = 8'h00;
   localparam logic [7:0] BYPASS_RST        = 8'h00;
   localparam logic [1:0] SSM_THREE_WIRE    = 2'h0;
   localparam logic       FUNC_IDLE_IN      = 1'b1;

   // ------------------------------------------------------------------
   // Pin functions; funcOut/funcOe/funcIn bit index is code minus one
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      FN_GPIO   = 4'h0,
      FN_TX     = 4'h1,
      FN_RX     = 4'h2,
      FN_SCK    = 4'h3,
      FN_MISO   = 4'h4,
      FN_MOSI   = 4'h5,
      FN_NSS    = 4'h6,
      FN_SDA    = 4'h7,
      FN_SCL    = 4'h8,
      FN_CMP    = 4'h9,
      FN_CMPA   = 4'hA,
      FN_SYSCLK = 4'hB
   } func_t;

   // Allocation order after the fixed serial pins, highest priority first.
   localparam int PRIO_LEN = 9;
   localparam func_t PRIO_ORDER [PRIO_LEN] = '{FN_SCK, FN_MISO, FN_MOSI,
      FN_NSS, FN_SDA, FN_SCL, FN_CMP, FN_CMPA, FN_SYSCLK};

endpackage

/* File: src/pin_alloc.sv */
`timescale 1ns/100ps

module pin_alloc
   import crossbar_pkg::*;
#(
   parameter int PINS = PIN_COUNT
) (
   input  wire logic [PINS-1:0]        bypass,
   input  wire logic [7:0]             routeFirst,
   input  wire logic                   nssOn,
   output func_t     [PINS-1:0]        pinFunc
);

   // ------------------------------------------------------------------
   // Enable decode for one function code
   // ------------------------------------------------------------------
   function automatic logic wanted(input func_t code,
                                   input logic [7:0] route,
                                   input logic spi_slave_select_line);
      logic w;
      w = 1'b0;
      case (code)
         FN_SCK, FN_MISO, FN_MOSI: w = route[BIT_SPI];
         FN_NSS:    w = route[BIT_SPI] & spi_slave_select_line;
         FN_SDA, FN_SCL: w = route[BIT_TWOWIRE];
         FN_CMP:    w = route[BIT_CMP];
         FN_CMPA:   w = route[BIT_CMP_ASYNC];
         FN_SYSCLK: w = route[BIT_SYSCLK];
         default:   w = 1'b0;
      endcase
      return w;
   endfunction

   // ------------------------------------------------------------------
   // Priority walk
   // ------------------------------------------------------------------
   // Bypassed pins start out as taken, so they look exactly like pins that
   // an earlier function already owns. A function that finds no free pin
   // is simply not brought out; nothing flags that to software.
   always_comb begin
      logic [PINS-1:0] taken;
      logic            found;
      taken = bypass;
      found = 1'b0;
      for (int p = 0; p < PINS; p++) begin
         pinFunc[p] = FN_GPIO;
      end
      // The serial pins are fixed and ignore priority and bypass.
      if (routeFirst[BIT_SERIAL]) begin
         pinFunc[SERIAL_TX_PIN] = FN_TX;
         pinFunc[SERIAL_RX_PIN] = FN_RX;
         taken[SERIAL_TX_PIN]   = 1'b1;
         taken[SERIAL_RX_PIN]   = 1'b1;
      end
      for (int k = 0; k < PRIO_LEN; k++) begin
         if (wanted(PRIO_ORDER[k], routeFirst, nssOn)) begin
            found = 1'b0;
            for (int p = 0; p < PINS; p++) begin
               if (!found && !taken[p]) begin
                  pinFunc[p] = PRIO_ORDER[k];
                  taken[p]   = 1'b1;
                  found      = 1'b1;
               end
            end
         end
      end
   end

endmodule

/* File: src/priority_crossbar_pin_assign.sv */
`timescale 1ns/100ps

// How it works
// - Each enabled function except serial takes lowest free pin.
// - Assigned pins are skipped by later functions.
// - Bypassed pins are skipped like assigned ones.
// - Serial transmit pin 4, receive pin 5.
// - Serial claims both pins together; with only one free pin left, two-wire routes SDA alone.
// - Leftover and bypassed pins stay general purpose; serial still takes pins 4 and 5 when they are bypassed.
// - SPI slave select routed only in 4-wire.
// - Input kind 1 digital, 0 analog; reset digital.
// - Analog pin: no pullup, driver or receiver.
// - Two-wire pins are always open-drain.
// - Pullups on open-drain pins unless pullup off.
// - Pullup off while pin drives low.
// - Crossbar on bit activates routing.
// - Crossbar off: inputs only, drivers off.
// - First routing register bits 7:6 read zero.
// - Bits 5,4,3 route comparators and clock.
// - Bits 2,1,0 route two-wire, SPI, serial.
// - Pullup off bit disables all pullups.
module priority_crossbar_pin_assign
   import crossbar_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [7:0]             sfrAddr,
   input  wire logic                   sfrWrEn,
   input  wire logic [7:0]             sfrWrData,
   input  wire logic                   sfrRdEn,
   output logic      [7:0]             sfrRdData,
   input  wire logic [1:0]             slaveSelectMode,
   input  wire logic [PIN_COUNT-1:0]   gpioOut,
   output logic      [PIN_COUNT-1:0]   gpioIn,
   input  wire logic [FUNC_COUNT-1:0]  funcOut,
   input  wire logic [FUNC_COUNT-1:0]  funcOe,
   output logic      [FUNC_COUNT-1:0]  funcIn,
   input  wire logic [PIN_COUNT-1:0]   padIn,
   output logic      [PIN_COUNT-1:0]   padOut,
   output logic      [PIN_COUNT-1:0]   padOe,
   output logic      [PIN_COUNT-1:0]   pullupOn,
   output logic      [PIN_COUNT-1:0]   inputEnable
);

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   logic                   rstMeta_q;   // First stage, read by rstSync_q only.
   logic                   rstSync_q;   // Released reset used everywhere.

   // Assertion is immediate, release waits two edges to stay clean.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   logic [7:0]             routeFirst_q;   // Function routing enables.
   logic                   xbarOn_q;       // Crossbar on.
   logic                   pullupOff_q;    // Global weak pullup disable.
   logic [PIN_COUNT-1:0]   inKind_q;       // 1 digital, 0 analog.
   logic [PIN_COUNT-1:0]   drive_q;        // 1 push-pull, 0 open-drain.
   logic [PIN_COUNT-1:0]   bypass_q;       // 1 skips the pin.

   // Writes take effect at the edge that takes them. Unmapped addresses
   // are ignored, so other devices can share the register bus.
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         routeFirst_q <= ROUTE_FIRST_RST;
         xbarOn_q     <= ROUTE_SECOND_RST[BIT_XBAR_ON];
         pullupOff_q  <= ROUTE_SECOND_RST[BIT_PULLUP_OFF];
         inKind_q     <= {INKIND_RST, INKIND_RST};
         drive_q      <= {DRIVE_RST, DRIVE_RST};
         bypass_q     <= {BYPASS_RST, BYPASS_RST};
      end else if (sfrWrEn) begin
         if (sfrAddr == ADDR_ROUTE_FIRST) begin
            routeFirst_q <= sfrWrData & ROUTE_FIRST_MASK;
         end else if (sfrAddr == ADDR_ROUTE_SECOND) begin
            xbarOn_q    <= sfrWrData[BIT_XBAR_ON];
            pullupOff_q <= sfrWrData[BIT_PULLUP_OFF];
         end else if (sfrAddr == ADDR_INKIND_P0) begin
            inKind_q[7:0] <= sfrWrData;
         end else if (sfrAddr == ADDR_INKIND_P1) begin
            inKind_q[15:8] <= sfrWrData;
         end else if (sfrAddr == ADDR_DRIVE_P0) begin
            drive_q[7:0] <= sfrWrData;
         end else if (sfrAddr == ADDR_DRIVE_P1) begin
            drive_q[15:8] <= sfrWrData;
         end else if (sfrAddr == ADDR_BYPASS_P0) begin
            bypass_q[7:0] <= sfrWrData;
         end else if (sfrAddr == ADDR_BYPASS_P1) begin
            bypass_q[15:8] <= sfrWrData;
         end
      end
   end

   // ------------------------------------------------------------------
   // Register read-back
   // ------------------------------------------------------------------
   logic [7:0]             rdValue;        // Selected register value.

   // Unmapped addresses and the unused bits read as zero.
   always_comb begin
      rdValue = 8'h00;
      if (sfrAddr == ADDR_ROUTE_FIRST) begin
         rdValue = routeFirst_q & ROUTE_FIRST_MASK;
      end else if (sfrAddr == ADDR_ROUTE_SECOND) begin
         rdValue[BIT_XBAR_ON]    = xbarOn_q;
         rdValue[BIT_PULLUP_OFF] = pullupOff_q;
      end else if (sfrAddr == ADDR_INKIND_P0) begin
         rdValue = inKind_q[7:0];
      end else if (sfrAddr == ADDR_INKIND_P1) begin
         rdValue = inKind_q[15:8];
      end else if (sfrAddr == ADDR_DRIVE_P0) begin
         rdValue = drive_q[7:0];
      end else if (sfrAddr == ADDR_DRIVE_P1) begin
         rdValue = drive_q[15:8];
      end else if (sfrAddr == ADDR_BYPASS_P0) begin
         rdValue = bypass_q[7:0];
      end else if (sfrAddr == ADDR_BYPASS_P1) begin
         rdValue = bypass_q[15:8];
      end
   end

   // Read data appear one edge after the strobe and drop to zero after.
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         sfrRdData <= 8'h00;
      end else begin
         sfrRdData <= sfrRdEn ? rdValue : 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // Priority allocation
   // ------------------------------------------------------------------
   func_t [PIN_COUNT-1:0]  pinFunc;        // Function owning each pin.
   logic                   nssOn;          // Four-wire SPI selected.

   assign nssOn = (slaveSelectMode != SSM_THREE_WIRE);

   pin_alloc #(
      .PINS       (PIN_COUNT)
   ) u_alloc (
      .bypass     (bypass_q),
      .routeFirst (routeFirst_q),
      .nssOn      (nssOn),
      .pinFunc    (pinFunc)
   );

   // ------------------------------------------------------------------
   // Pin cells
   // ------------------------------------------------------------------
   logic [PIN_COUNT-1:0]   smbMask;        // Pins carrying two-wire lines.
   logic [PIN_COUNT-1:0]   padOut_d;
   logic [PIN_COUNT-1:0]   padOe_d;
   logic [PIN_COUNT-1:0]   pullupOn_d;
   logic [PIN_COUNT-1:0]   gpioIn_d;
   logic [FUNC_COUNT-1:0]  funcIn_d;

   // While the crossbar is off every pin is treated as a plain input, so
   // routing settings can be staged safely before the crossbar goes on.
   always_comb begin
      func_t f;
      logic  val;
      logic  req;
      logic  od;
      logic  dig;
      f        = FN_GPIO;
      val      = 1'b0;
      req      = 1'b0;
      od       = 1'b0;
      dig      = 1'b0;
      smbMask  = '0;
      padOut_d = '0;
      padOe_d  = '0;
      pullupOn_d = '0;
      gpioIn_d = '0;
      funcIn_d = {FUNC_COUNT{FUNC_IDLE_IN}};
      for (int p = 0; p < PIN_COUNT; p++) begin
         f   = xbarOn_q ? pinFunc[p] : FN_GPIO;
         dig = inKind_q[p];
         if (f == FN_GPIO) begin
            val = gpioOut[p];
            req = 1'b1;
         end else begin
            val = funcOut[int'(f) - 1];
            req = funcOe[int'(f) - 1];
         end
         smbMask[p] = (f == FN_SDA) || (f == FN_SCL);
         od = !drive_q[p] || smbMask[p];
         if (!xbarOn_q || !dig) begin
            padOe_d[p]  = 1'b0;
            padOut_d[p] = 1'b0;
         end else if (od) begin
            padOe_d[p]  = req && !val;
            padOut_d[p] = 1'b0;
         end else begin
            padOe_d[p]  = req;
            padOut_d[p] = val;
         end
         // Pullup only on digital open-drain pins, or on any digital pin while the crossbar is off.
         pullupOn_d[p] = dig && !pullupOff_q
            && (od || !xbarOn_q)
            && !(padOe_d[p] && !padOut_d[p]);
         gpioIn_d[p] = dig && padIn[p];
         if (f != FN_GPIO && dig) begin
            funcIn_d[int'(f) - 1] = padIn[p];
         end
      end
   end

   // Every pad and peripheral output is taken from a flip-flop.
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         padOut      <= '0;
         padOe       <= '0;
         pullupOn    <= {PIN_COUNT{1'b1}};
         inputEnable <= {PIN_COUNT{1'b1}};
         gpioIn      <= '0;
         funcIn      <= {FUNC_COUNT{FUNC_IDLE_IN}};
      end else begin
         padOut      <= padOut_d;
         padOe       <= padOe_d;
         pullupOn    <= pullupOn_d;
         inputEnable <= inKind_q;
         gpioIn      <= gpioIn_d;
         funcIn      <= funcIn_d;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic [PIN_COUNT-1:0]   ownedMask;      // Pins given to a function.
   logic [PIN_COUNT-1:0]   nssMask;        // Pins given slave select.
   logic [PIN_COUNT-1:0]   fixedMask;      // Fixed serial pins in use.

   always_comb begin
      for (int p = 0; p < PIN_COUNT; p++) begin
         ownedMask[p] = (pinFunc[p] != FN_GPIO);
         nssMask[p]   = (pinFunc[p] == FN_NSS);
      end
      fixedMask = '0;
      fixedMask[SERIAL_TX_PIN] = routeFirst_q[BIT_SERIAL];
      fixedMask[SERIAL_RX_PIN] = routeFirst_q[BIT_SERIAL];
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync_q);

   sequence rdFirstS;
      sfrRdEn && (sfrAddr == ADDR_ROUTE_FIRST);
   endsequence

   sequence xbarOffWrS;
      sfrWrEn && (sfrAddr == ADDR_ROUTE_SECOND)
         && !sfrWrData[BIT_XBAR_ON];
   endsequence

   a_reg_reserved: assert property (rdFirstS |=>
      sfrRdData[7:6] == 2'b00 && sfrRdData[5:0] == $past(routeFirst_q[5:0]))
      else $error("Routing register read-back wrong.");

   a_xbar_off_drv: assert property (xbarOffWrS |=> ##1
      (padOe == '0) [*2])
      else $error("Pad driven with crossbar off.");

   a_analog_quiet: assert property (
      ((padOe | pullupOn | inputEnable) & ~$past(inKind_q)) == '0)
      else $error("Analog pin not quiet.");

   a_twowire_od: assert property (
      (padOut & $past(smbMask)) == '0)
      else $error("Two-wire pin driven high.");

   a_low_no_pull: assert property (
      (padOe & ~padOut & pullupOn) == '0)
      else $error("Pullup on while driving low.");

   a_pull_disable: assert property ($past(pullupOff_q) |->
      pullupOn == '0)
      else $error("Pullup on while disabled.");

   a_serial_fixed: assert property (routeFirst_q[BIT_SERIAL] |->
      pinFunc[SERIAL_TX_PIN] == FN_TX && pinFunc[SERIAL_RX_PIN] == FN_RX)
      else $error("Serial pins not fixed.");

   a_bypass_skip: assert property (
      (ownedMask & bypass_q & ~fixedMask) == '0)
      else $error("Bypassed pin allocated.");

   a_spi_three: assert property (
      !nssOn |-> nssMask == '0)
      else $error("Slave select routed in 3-wire mode.");

   a_lsb_first: assert property (
      (routeFirst_q == 8'h06) && (bypass_q == '0) |->
      pinFunc[0] == FN_SCK && pinFunc[2] == FN_MOSI
      && pinFunc[4] == FN_SDA && pinFunc[5] == FN_SCL
      && ownedMask[PIN_COUNT-1:6] == '0)
      else $error("Priority allocation order wrong.");

endmodule
